//--- bench/host_adapter.sv
// Purpose: host adapter model at the far end of the debug link
// Assumes: link clock idles low and only runs inside frames
// Notes:   data is set mid-cycle and sampled just before each rise
module host_adapter
(
    output logic      lclk,  // link clock to the device
    output logic      hd,    // host data value
    output logic      hd_en, // host drives the data line
    input  wire logic line   // resolved data line level
);
    timeunit 1ns;
    timeprecision 1ps;

    // one link cycle: set the line, sample it, then rise and fall
    task automatic pulse(input logic en, input logic d, output logic s);
        hd_en = en;
        hd = d;
        #7.5;
        s = line;
        lclk = 1'b1;
        #7.5;
        lclk = 1'b0;
    endtask

    // whole frame: idle bits for halt sync, start, instruction, byte
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
                         output logic [7:0] rd);
        logic s;
        for (int i = 0; i < 3; i++)
            pulse(1'b1, 1'b1, s);
        pulse(1'b1, 1'b0, s);
        pulse(1'b1, ins[0], s);
        pulse(1'b1, ins[1], s);
        // writes drive the byte lsb first, reads release and sample
        for (int i = 0; i < 8; i++)
        begin
            pulse(ins[0], wd[i], s);
            rd[i] = s;
        end
        hd_en = 1'b0;
    endtask

    // idle: clock still, line released
    initial
    begin
        lclk = 1'b0;
        hd = 1'b1;
        hd_en = 1'b0;
    end
endmodule

//--- bench/testbench.sv
// Purpose: self-checking bench of the debug link register block
// Assumes: host model makes the link clock at a 15 ns period
// Notes:   released data line is pulled up, so idle reads give ff
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import debug_link_pkg::*;

    localparam logic [7:0] PART_V = 8'h3c; // arbitrary value
    localparam logic [7:0] REV_V  = 8'h91; // arbitrary value

    logic       clk;        // core clock
    logic       arst_n;     // async reset, active low
    logic       halted;     // core halted
    logic       lclk;       // link clock
    logic       hd;         // host data
    logic       hd_en;      // host drives data
    logic       dout;       // device data value
    logic       oe;         // device drives data
    logic       owns;       // pins given to link
    logic       flash_en;   // programming enabled
    logic [7:0] pdat;       // forwarded byte
    logic       stb;        // forwarded byte strobe
    wire  logic line;       // resolved data line
    logic [7:0] rd;         // byte read by host
    logic [7:0] s;          // select value
    logic [7:0] w;          // written byte
    logic [7:0] pd;         // expected programming data
    logic       got;        // strobe seen
    int         seed;       // random seed
    int         error_cnt;  // mismatches
    int         num_checks; // comparisons

    // device wins, then host, else pull-up
    assign line = oe ? dout : (hd_en ? hd : 1'b1);

    debug_link_regs #(.PART_ID(PART_V), .REV_ID(REV_V)) dut_u
    (
        .CLK(clk), .ARST_N(arst_n), .DEBUG_LINK_CLOCK(lclk),
        .DEBUG_DATA_IN(line), .HALTED(halted), .DEBUG_DATA_OUT(dout),
        .DEBUG_DATA_OE(oe), .LINK_OWNS_PINS(owns),
        .FLASH_PROG_EN(flash_en), .PROG_DATA(pdat), .PROG_DATA_STB(stb)
    );

    host_adapter host_u
    (
        .lclk(lclk), .hd(hd), .hd_en(hd_en), .line(line)
    );

    // core clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // expected data read for a select value
    function automatic logic [7:0] exp_rd(input logic [7:0] sv,
                                          input logic [7:0] pv);
        case (sv)
            SEL_PART:      return PART_V;
            SEL_REV:       return REV_V;
            SEL_PROG_DATA: return pv;
            default:       return 8'h00;
        endcase
    endfunction

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // note whether any strobe comes within a bounded span
    task automatic watch_stb(input int n);
        got = 1'b0;
        repeat (n) @(posedge clk) got |= stb;
        #1;
    endtask

    // verdict
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // bounded run
    initial
    begin
        #50000;
        error_cnt++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        arst_n = 1'b0;
        halted = 1'b0;
        seed = 32'haacc;
        error_cnt = 0;
        num_checks = 0;
        pd = RST_PROG_DATA;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(flash_en, 8'h00);
        check(oe, 8'h00);
        // start ignored while running: line stays pulled up
        host_u.frame(2'b10, 8'h00, rd);
        check(rd, 8'hff);
        @(posedge clk) halted <= 1'b1;
        #1;
        check(owns, 8'h00);
        @(posedge clk);
        #1;
        check(owns, 8'h01);
        host_u.frame(2'b10, 8'h00, rd);
        check(rd, RST_SELECT);
        // fixed and random selects, writes to read-only places
        for (int i = 0; i < 8; i++)
        begin
            s = (i == 0) ? SEL_PART : (i == 1) ? SEL_REV : $random(seed);
            if (s === SEL_PROG_EN)
                s = 8'h33;
            w = $random(seed);
            host_u.frame(2'b11, s, rd);
            host_u.frame(2'b10, 8'h00, rd);
            check(rd, s);
            host_u.frame(2'b01, w, rd);
            if (s === SEL_PROG_DATA)
                pd = w;
            host_u.frame(2'b00, 8'h00, rd);
            check(rd, exp_rd(s, pd));
        end
        // data stored but not forwarded before enabling
        host_u.frame(2'b11, SEL_PROG_DATA, rd);
        w = $random(seed);
        host_u.frame(2'b01, w, rd);
        watch_stb(10);
        check(got, 8'h00);
        host_u.frame(2'b00, 8'h00, rd);
        check(rd, w);
        // broken then proper unlock sequence
        host_u.frame(2'b11, SEL_PROG_EN, rd);
        // a stray value between the two codes drops the arming
        host_u.frame(2'b01, PROG_CODE_ARM, rd);
        host_u.frame(2'b01, 8'h05, rd);
        host_u.frame(2'b01, PROG_CODE_GO, rd);
        repeat (6) @(posedge clk);
        #1;
        check(flash_en, 8'h00);
        host_u.frame(2'b01, PROG_CODE_ARM, rd);
        host_u.frame(2'b01, PROG_CODE_GO, rd);
        repeat (6) @(posedge clk);
        #1;
        check(flash_en, 8'h01);
        // enable register reads back the last code written
        host_u.frame(2'b00, 8'h00, rd);
        check(rd, PROG_CODE_GO);
        // every flash command forwarded once enabled
        host_u.frame(2'b11, SEL_PROG_DATA, rd);
        for (int i = 0; i < 5; i++)
        begin
            w = (i == 0) ? CMD_DEV_ERASE : (i == 1) ? CMD_BLK_READ :
                (i == 2) ? CMD_BLK_WRITE : (i == 3) ? CMD_PAGE_ERASE :
                $random(seed);
            host_u.frame(2'b01, w, rd);
            watch_stb(8);
            check(got, 8'h01);
            check(pdat, w);
        end
        // second reset clears enable and select
        @(posedge clk) arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(flash_en, 8'h00);
        host_u.frame(2'b10, 8'h00, rd);
        check(rd, RST_SELECT);
        tally_and_finish();
    end
endmodule

//--- common/debug_link_pkg.sv
// Purpose: shared constants and types of the debug link register block
// Assumes: one byte per link transfer, least significant bit first
// Notes:   selector codes and programming codes are fixed by hardware
package debug_link_pkg;
    // register selector codes
    localparam logic [7:0] SEL_PART      = 8'h00;
    localparam logic [7:0] SEL_REV       = 8'h01;
    localparam logic [7:0] SEL_PROG_EN   = 8'h02;
    localparam logic [7:0] SEL_PROG_DATA = 8'hb4;
    // reset values
    localparam logic [7:0] RST_SELECT    = 8'h00;
    localparam logic [7:0] RST_PROG_EN   = 8'h00;
    localparam logic [7:0] RST_PROG_DATA = 8'h00;
    localparam logic [7:0] RST_READ      = 8'h00;
    // programming enable unlock codes, in order
    localparam logic [7:0] PROG_CODE_ARM = 8'h02;
    localparam logic [7:0] PROG_CODE_GO  = 8'h01;
    // flash commands carried through the programming data register
    localparam logic [7:0] CMD_DEV_ERASE  = 8'h03;
    localparam logic [7:0] CMD_BLK_READ   = 8'h06;
    localparam logic [7:0] CMD_BLK_WRITE  = 8'h07;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
    // frame timing
    localparam logic       START_LEVEL = 1'b0;
    localparam logic [2:0] INS_LAST    = 3'h1;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [2:0] CNT_ZERO    = 3'h0;
    localparam logic [2:0] CNT_ONE     = 3'h1;

    // link frame states, gray in the order idle-instr-write-read
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INSTR = 2'b01,
        ST_WRITE = 2'b11,
        ST_READ  = 2'b10
    } link_state_t;

    // two-bit instruction sent after the start bit
    typedef enum logic [1:0] {
        INS_DATA_READ  = 2'b00,
        INS_DATA_WRITE = 2'b01,
        INS_ADDR_READ  = 2'b10,
        INS_ADDR_WRITE = 2'b11
    } instr_t;

    // decoded register target
    typedef enum logic [2:0] {
        TGT_PART, TGT_REV, TGT_PROG_EN, TGT_PROG_DATA, TGT_NONE
    } target_t;

    // frame progress at the link
    typedef struct packed {
        link_state_t state;
        instr_t      instr;
        logic [2:0]  cnt;
        logic [7:0]  shift;
        logic        dout;
        logic        oe;
    } frame_t;

    // link-side register contents
    typedef struct packed {
        logic [7:0] select;
        logic [7:0] prog_en_val;
        logic       armed;
        logic       prog_en;
        logic [7:0] prog_data;
        logic       toggle;
    } regs_t;
endpackage

//--- rtl/debug_link_regs.sv
// Purpose: register access side of the two-wire debug link
// Assumes: host data is launched while the link clock is low and sampled on its rising edge
// Notes:   link registers are reachable from the link only
module debug_link_regs
#(
    parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] REV_ID  = 8'h0c  // arbitrary value
)
(
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic       DEBUG_LINK_CLOCK,
    input  wire logic       DEBUG_DATA_IN,
    input  wire logic       HALTED,
    output logic            DEBUG_DATA_OUT,
    output logic            DEBUG_DATA_OE,
    output logic            LINK_OWNS_PINS,
    output logic            FLASH_PROG_EN,
    output logic [7:0]      PROG_DATA,
    output logic            PROG_DATA_STB
);
    import debug_link_pkg::*;

    // map a selector value to its register
    function automatic target_t decode_sel(input logic [7:0] sel);
        target_t t;
        unique case (sel)
            SEL_PART:      t = TGT_PART;
            SEL_REV:       t = TGT_REV;
            SEL_PROG_EN:   t = TGT_PROG_EN;
            SEL_PROG_DATA: t = TGT_PROG_DATA;
            default:       t = TGT_NONE;
        endcase
        return t;
    endfunction

    frame_t     frame;        // link frame progress
    frame_t     next_frame;   // next frame progress
    regs_t      regs;         // link registers
    regs_t      next_regs;    // next link registers
    logic       halt_s1;      // halted, first sync stage
    logic       halt_s2;      // halted, usable in link domain
    logic       wr_fire;      // last write bit taken this edge
    logic [7:0] wr_byte;      // completed write byte
    logic       rd_load;      // read data loaded this edge
    logic [7:0] rd_value;     // byte for a read
    target_t    tgt;          // decoded current selector

    // halted level into the link domain
    always_ff @(posedge DEBUG_LINK_CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            halt_s1 <= 1'b0;
            halt_s2 <= 1'b0;
        end
        else
        begin
            halt_s1 <= HALTED;
            halt_s2 <= halt_s1;
        end
    end

    // byte answered for reads
    always_comb
    begin
        tgt = decode_sel(regs.select);
        rd_value = RST_READ;
        // the instruction is still arriving at the load edge
        if (instr_t'(wr_byte[7:6]) == INS_ADDR_READ)
            rd_value = regs.select;
        else
        begin
            unique case (tgt)
                TGT_PART:      rd_value = PART_ID;
                TGT_REV:       rd_value = REV_ID;
                TGT_PROG_EN:   rd_value = regs.prog_en_val;
                TGT_PROG_DATA: rd_value = regs.prog_data;
                TGT_NONE:      rd_value = RST_READ;
            endcase
        end
    end

    // frame sequencing: start, instruction, byte out or in
    always_comb
    begin
        next_frame = frame;
        wr_fire = 1'b0;
        rd_load = 1'b0;
        wr_byte = {DEBUG_DATA_IN, frame.shift[7:1]};
        next_frame.cnt = frame.cnt + CNT_ONE;
        next_frame.shift = wr_byte;
        unique case (frame.state)
            ST_IDLE:
            begin
                next_frame.cnt = CNT_ZERO;
                // only a halted core lends its pins
                if (halt_s2 && DEBUG_DATA_IN == START_LEVEL)
                    next_frame.state = ST_INSTR;
            end
            ST_INSTR:
            begin
                if (frame.cnt == INS_LAST)
                begin
                    next_frame.instr = instr_t'(wr_byte[7:6]);
                    next_frame.cnt = CNT_ZERO;
                    if (!wr_byte[6])
                        next_frame.state = ST_READ;
                    else
                        next_frame.state = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                if (frame.cnt == BIT_LAST)
                begin
                    wr_fire = 1'b1;
                    next_frame.state = ST_IDLE;
                end
            end
            ST_READ:
            begin
                next_frame.dout = frame.shift[0];
                next_frame.shift = {1'b0, frame.shift[7:1]};
                if (frame.cnt == BIT_LAST)
                begin
                    next_frame.oe = 1'b0;
                    next_frame.state = ST_IDLE;
                end
            end
        endcase
        // read byte is driven bit 0 first on the data line
        if (frame.state == ST_INSTR && frame.cnt == INS_LAST
            && !wr_byte[6])
        begin
            rd_load = 1'b1;
            next_frame.dout = rd_value[0];
            next_frame.shift = {1'b0, rd_value[7:1]};
            next_frame.oe = halt_s2;
        end
        // pins go back at once if the core resumes
        if (!halt_s2)
        begin
            next_frame.oe = 1'b0;
            next_frame.state = ST_IDLE;
        end
    end

    // frame registers
    always_ff @(posedge DEBUG_LINK_CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            frame <= '{ST_IDLE, INS_DATA_READ, CNT_ZERO,
                       RST_READ, 1'b0, 1'b0};
        end
        else
            frame <= next_frame;
    end

    // register writes from the link
    always_comb
    begin
        next_regs = regs;
        if (wr_fire)
        begin
            if (frame.instr == INS_ADDR_WRITE)
                next_regs.select = wr_byte;
            else
            begin
                unique case (tgt)
                    TGT_PROG_EN:
                    begin
                        next_regs.prog_en_val = wr_byte;
                        next_regs.armed = (wr_byte == PROG_CODE_ARM);
                        // sticky until system reset
                        if (regs.armed && wr_byte == PROG_CODE_GO)
                            next_regs.prog_en = 1'b1;
                    end
                    TGT_PROG_DATA:
                    begin
                        next_regs.prog_data = wr_byte;
                        if (regs.prog_en)
                            next_regs.toggle = ~regs.toggle;
                    end
                    TGT_PART, TGT_REV, TGT_NONE:
                        next_regs.select = regs.select;
                endcase
            end
        end
    end

    // link registers
    always_ff @(posedge DEBUG_LINK_CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            regs <= '{RST_SELECT, RST_PROG_EN, 1'b0, 1'b0,
                      RST_PROG_DATA, 1'b0};
        end
        else
            regs <= next_regs;
    end

    assign DEBUG_DATA_OUT = frame.dout;
    assign DEBUG_DATA_OE  = frame.oe;

    // core domain: syncs, strobe and pin ownership
    logic [1:0] en_sync;      // programming enable sync
    logic [2:0] tog_sync;     // data event toggle sync and history
    logic [1:0] next_en;      // next enable sync
    logic [2:0] next_tog;     // next toggle sync
    logic       next_owns;    // next pin ownership
    logic       next_stb;     // next data strobe
    logic [7:0] next_pdata;   // next forwarded data

    // event edge from the second and third toggle stages
    always_comb
    begin
        next_en = {en_sync[0], regs.prog_en};
        next_tog = {tog_sync[1:0], regs.toggle};
        next_owns = HALTED;
        next_stb = tog_sync[2] ^ tog_sync[1];
        next_pdata = PROG_DATA;
        // link data stays still for a whole frame
        if (next_stb)
            next_pdata = regs.prog_data;
    end

    // core registers; no firmware port reaches the link registers
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            en_sync <= 2'b00;
            tog_sync <= 3'b000;
            LINK_OWNS_PINS <= 1'b0;
            FLASH_PROG_EN <= 1'b0;
            PROG_DATA_STB <= 1'b0;
            PROG_DATA <= RST_PROG_DATA;
        end
        else
        begin
            en_sync <= next_en;
            tog_sync <= next_tog;
            LINK_OWNS_PINS <= next_owns;
            FLASH_PROG_EN <= en_sync[1];
            PROG_DATA_STB <= next_stb;
            PROG_DATA <= next_pdata;
        end
    end

    // a read drives exactly eight bits then releases
    sequence read_burst_s;
        DEBUG_DATA_OE [*8] ##1 !DEBUG_DATA_OE;
    endsequence

    read_len_a: assert property (
        @(posedge DEBUG_LINK_CLOCK) disable iff (!ARST_N)
        ($rose(DEBUG_DATA_OE) && halt_s2)
        |-> read_burst_s or (##[1:8] !halt_s2))
        else $error("read burst length wrong");

    oe_halt_a: assert property (
        @(posedge DEBUG_LINK_CLOCK) disable iff (!ARST_N)
        DEBUG_DATA_OE |-> $past(halt_s2))
        else $error("data driven while core running");

    sel_write_a: assert property (
        @(posedge DEBUG_LINK_CLOCK) disable iff (!ARST_N)
        (wr_fire && frame.instr == INS_ADDR_WRITE)
        |=> regs.select == $past(wr_byte))
        else $error("selector not updated");

    part_read_a: assert property (
        @(posedge DEBUG_LINK_CLOCK) disable iff (!ARST_N)
        (rd_load && instr_t'(wr_byte[7:6]) == INS_DATA_READ
         && regs.select == SEL_PART)
        |=> {frame.shift[6:0], frame.dout} == PART_ID)
        else $error("part identity read wrong");

    rev_read_a: assert property (
        @(posedge DEBUG_LINK_CLOCK) disable iff (!ARST_N)
        (rd_load && instr_t'(wr_byte[7:6]) == INS_DATA_READ
         && regs.select == SEL_REV)
        |=> {frame.shift[6:0], frame.dout} == REV_ID)
        else $error("revision read wrong");

    prog_unlock_a: assert property (
        @(posedge DEBUG_LINK_CLOCK) disable iff (!ARST_N)
        (wr_fire && frame.instr == INS_DATA_WRITE && tgt == TGT_PROG_EN
         && wr_byte == PROG_CODE_GO && regs.armed)
        |=> regs.prog_en [*2])
        else $error("programming not enabled");

    prog_stuck_a: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        FLASH_PROG_EN |=> FLASH_PROG_EN)
        else $error("programming enable dropped");

    data_fwd_a: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        PROG_DATA_STB |-> PROG_DATA == regs.prog_data ##1 !PROG_DATA_STB)
        else $error("programming data strobe wrong");

    sel_decode_a: assert property (
        @(posedge DEBUG_LINK_CLOCK) disable iff (!ARST_N)
        (regs.select == SEL_PROG_DATA) |-> tgt == TGT_PROG_DATA)
        else $error("selector decode wrong");
endmodule
